// ===== shared/aocm_consts.svh
// Offsets, field positions, scaling limits and codes of the analog output code mapper.
`ifndef AOCM_CONSTS_SVH
`define AOCM_CONSTS_SVH

`define AOCM_ADDR_W 8
`define AOCM_PARAM_BYTES 6
`define AOCM_CHANNELS 4

`define AOCM_IDX_ALARM_CFG 8'h00
`define AOCM_IDX_SPARE 8'h01
`define AOCM_IDX_CH0_RANGE 8'h02
`define AOCM_OFS_OUT_WORD0 8'h20
`define AOCM_OFS_DIAG_REC 8'h30
`define AOCM_OFS_STATUS 8'h34

`define AOCM_ALARM_EN_BIT 6

`define AOCM_DIAG_MOD_FAULT_BIT 0
`define AOCM_DIAG_ZERO_BIT 1
`define AOCM_DIAG_EXT_ERR_BIT 2
`define AOCM_DIAG_CH_ERR_BIT 3
`define AOCM_DIAG_CLASS_ANALOG 4'b0101
`define AOCM_DIAG_CH_INFO_BIT 4

`define AOCM_FN_NONE 8'h00
`define AOCM_FN_L_BIP10V 8'h01
`define AOCM_FN_L_V1TO5 8'h02
`define AOCM_FN_L_BIP20MA 8'h03
`define AOCM_FN_L_MA4TO20 8'h04
`define AOCM_FN_L_UNI10V 8'h05
`define AOCM_FN_L_MA0TO20 8'h06
`define AOCM_FN_T_BIP10V 8'h09
`define AOCM_FN_T_V1TO5 8'h0A
`define AOCM_FN_T_BIP20MA 8'h0B
`define AOCM_FN_T_MA4TO20 8'h0C
`define AOCM_FN_T_UNI10V 8'h0D
`define AOCM_FN_T_MA0TO20 8'h0E
`define AOCM_FN_T_BIP4V 8'h0F
`define AOCM_FN_T_BIP400MV 8'h10

`define AOCM_LEGACY_GAIN 21'sd27
`define AOCM_LEGACY_SHIFT 4
`define AOCM_LEVEL_MAX 16'sh7FFF
`define AOCM_LEVEL_MIN 16'sh8001

`endif

// ===== shared/aocm_pkg.sv
// Types of the analog output code mapper.
package aocm_pkg;

   typedef enum logic [3:0] {
      AOCM_RANGE_OFF,
      AOCM_RANGE_BIP10V,
      AOCM_RANGE_UNI10V,
      AOCM_RANGE_V1TO5,
      AOCM_RANGE_MA4TO20,
      AOCM_RANGE_BIP20MA,
      AOCM_RANGE_MA0TO20,
      AOCM_RANGE_BIP4V,
      AOCM_RANGE_BIP400MV
   } aocm_range_type;

   typedef enum logic {
      AOCM_DIAG_IDLE,
      AOCM_DIAG_SEND
   } aocm_diag_state_type;

   typedef struct packed {
      logic [5:0][7:0] param;
      logic [3:0][15:0] word;
      logic [3:0][15:0] level;
      logic loaded;
      logic err_seen;
      aocm_diag_state_type diag_state;
      logic [31:0] diag_rec;
      logic nv_save;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } aocm_state_type;

endpackage

// ===== rtl/aocm_top.sv
// Analog output code mapper: APB registers, per-channel code mapping and diagnostic record.
//
// Function
// - Legacy bipolar 10 V and 0 to 10 V: 16384 is full scale, linear.
// - Legacy 1 to 5 V: code 0 is 1 V, 16384 is 5 V.
// - Legacy 4 to 20 mA: code 0 is 4 mA, 16384 is 20 mA.
// - Legacy bipolar 20 mA: plus or minus 16384 is plus or minus 20 mA.
// - Two's complement bipolar 10 V: plus or minus 27648 is full scale.
// - Two's complement 1 to 5 V: 0 is 1 V, 27648 is 5 V.
// - Two's complement bipolar 4 V and 400 mV: 27648 is full scale.
// - Two's complement 4 to 20 mA: 0 is 4 mA, 27648 is 20 mA.
// - Two's complement bipolar 20 mA: plus or minus 27648 is full scale.
// - Two's complement word is signed; top bit is the sign.
// - Each channel takes range, quantity and format from its own function number.
// - Six parameter bytes are kept in non-volatile storage across power loss.
// - Parameter byte 0 bit 6 enables alarms; other bits and byte 1 reserved.
// - With alarms enabled, a detected error sends a four-byte diagnostic record.
// - Only diagnostic bytes 0 and 1 carry information; bytes 2 and 3 are zero.
// - Byte 0: malfunction bit 0, zero bit 1, external bit 2, channel bit 3.
// - Byte 1: class 0101 in bits 0 to 3, bit 4 channel information.
// - Legacy word: bit 0 overflow, bit 1 error, bit 2 zero, value above.
// - Function 00h is off; 01h to 06h legacy; 09h to 10h two's complement.
`timescale 1ns/100ps
`include "aocm_consts.svh"

module aocm_top (
   input wire logic clock,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [47:0] nv_image_in,
   output logic [47:0] nv_image_out,
   output logic nv_save,
   input wire logic module_fault,
   input wire logic [3:0] channel_fault,
   output logic [63:0] channel_level,
   output logic [15:0] channel_range,
   output logic diag_valid,
   output logic [31:0] diag_record,
   input wire logic diag_ready
);

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel mapping.

   aocm_pkg::aocm_state_type s_q;
   aocm_pkg::aocm_state_type s_d;

   logic [3:0][15:0] map_level;
   logic [3:0] map_legacy;
   logic [3:0] map_bad_fn;
   logic [3:0] word_fault;
   aocm_pkg::aocm_range_type [3:0] map_range;

   // Legacy words are rescaled so that every range drives the converter at one
   // full scale of 27648; the analog front end then only needs the range select.
   function automatic logic [15:0] legacy_level(input logic [15:0] w);
      logic signed [20:0] scaled;
      scaled = 21'(signed'({w[15:3], 3'b000})) * `AOCM_LEGACY_GAIN;
      scaled = scaled >>> `AOCM_LEGACY_SHIFT;
      if (scaled > 21'(`AOCM_LEVEL_MAX)) begin
         return `AOCM_LEVEL_MAX;
      end else if (scaled < 21'(`AOCM_LEVEL_MIN)) begin
         return `AOCM_LEVEL_MIN;
      end
      return scaled[15:0];
   endfunction

   genvar ch;
   generate
      for (ch = 0; ch < `AOCM_CHANNELS; ch++) begin : g_map
         always_comb begin
            map_legacy[ch] = 1'b0;
            map_bad_fn[ch] = 1'b0;
            map_range[ch] = aocm_pkg::AOCM_RANGE_OFF;
            case (s_q.param[`AOCM_IDX_CH0_RANGE + ch])
               `AOCM_FN_NONE: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_OFF;
               end
               `AOCM_FN_L_BIP10V: begin
                  map_legacy[ch] = 1'b1;
                  map_range[ch] = aocm_pkg::AOCM_RANGE_BIP10V;
               end
               `AOCM_FN_L_UNI10V: begin
                  map_legacy[ch] = 1'b1;
                  map_range[ch] = aocm_pkg::AOCM_RANGE_UNI10V;
               end
               `AOCM_FN_L_V1TO5: begin
                  map_legacy[ch] = 1'b1;
                  map_range[ch] = aocm_pkg::AOCM_RANGE_V1TO5;
               end
               `AOCM_FN_L_MA4TO20: begin
                  map_legacy[ch] = 1'b1;
                  map_range[ch] = aocm_pkg::AOCM_RANGE_MA4TO20;
               end
               `AOCM_FN_L_BIP20MA: begin
                  map_legacy[ch] = 1'b1;
                  map_range[ch] = aocm_pkg::AOCM_RANGE_BIP20MA;
               end
               `AOCM_FN_L_MA0TO20: begin
                  map_legacy[ch] = 1'b1;
                  map_range[ch] = aocm_pkg::AOCM_RANGE_MA0TO20;
               end
               `AOCM_FN_T_BIP10V: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_BIP10V;
               end
               `AOCM_FN_T_UNI10V: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_UNI10V;
               end
               `AOCM_FN_T_V1TO5: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_V1TO5;
               end
               `AOCM_FN_T_MA4TO20: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_MA4TO20;
               end
               `AOCM_FN_T_BIP20MA: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_BIP20MA;
               end
               `AOCM_FN_T_MA0TO20: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_MA0TO20;
               end
               `AOCM_FN_T_BIP4V: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_BIP4V;
               end
               `AOCM_FN_T_BIP400MV: begin
                  map_range[ch] = aocm_pkg::AOCM_RANGE_BIP400MV;
               end
               default: begin
                  map_bad_fn[ch] = 1'b1;
               end
            endcase
            if (map_range[ch] == aocm_pkg::AOCM_RANGE_OFF) begin
               map_level[ch] = 16'h0000;
            end else if (map_legacy[ch]) begin
               map_level[ch] = legacy_level(s_q.word[ch]);
            end else begin
               map_level[ch] = s_q.word[ch];
            end
            word_fault[ch] = map_legacy[ch] & (s_q.word[ch][0] | s_q.word[ch][1]);
         end
         assign channel_range[ch*4 +: 4] = map_range[ch];
         assign channel_level[ch*16 +: 16] = s_q.level[ch];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Error sources and the diagnostic record.

   logic err_module;
   logic err_external;
   logic err_channel;
   logic err_any;
   logic [31:0] diag_now;

   always_comb begin
      err_module = module_fault | (|map_bad_fn);
      err_external = |channel_fault;
      err_channel = |(channel_fault | word_fault);
      err_any = err_module | err_external | err_channel;
      diag_now = 32'h0000_0000;
      diag_now[`AOCM_DIAG_MOD_FAULT_BIT] = err_module;
      diag_now[`AOCM_DIAG_ZERO_BIT] = 1'b0;
      diag_now[`AOCM_DIAG_EXT_ERR_BIT] = err_external;
      diag_now[`AOCM_DIAG_CH_ERR_BIT] = err_channel;
      diag_now[11:8] = `AOCM_DIAG_CLASS_ANALOG;
      diag_now[8 + `AOCM_DIAG_CH_INFO_BIT] = err_channel;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode.

   logic setup;
   logic access;
   logic [7:0] widx;
   logic out_hit;
   logic [1:0] out_ch;
   logic mapped;

   always_comb begin
      setup = psel & ~penable;
      access = psel & penable & s_q.pready;
      widx = {2'b00, paddr[7:2]};
      out_hit = (paddr[7:4] == 4'(`AOCM_OFS_OUT_WORD0 >> 4)) && (paddr[1:0] == 2'b00);
      out_ch = paddr[3:2];
      mapped = (paddr[1:0] == 2'b00)
         && ((widx < `AOCM_PARAM_BYTES) || out_hit
         || (paddr == `AOCM_OFS_DIAG_REC) || (paddr == `AOCM_OFS_STATUS));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      s_d = s_q;
      s_d.nv_save = 1'b0;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.err_seen = err_any;
      s_d.level = map_level;

      // Parameters come back from storage in the first cycle after reset.
      if (!s_q.loaded) begin
         s_d.loaded = 1'b1;
         for (int i = 0; i < `AOCM_PARAM_BYTES; i++) begin
            s_d.param[i] = nv_image_in[i*8 +: 8];
         end
         s_d.param[`AOCM_IDX_ALARM_CFG] = 8'h00;
         s_d.param[0][`AOCM_ALARM_EN_BIT] = nv_image_in[`AOCM_ALARM_EN_BIT];
         s_d.param[`AOCM_IDX_SPARE] = 8'h00;
      end

      // Answer one cycle after setup so that read data comes from a register.
      if (setup) begin
         s_d.pready = 1'b1;
         s_d.pslverr = ~mapped;
         s_d.prdata = 32'h0000_0000;
         if (!pwrite && mapped) begin
            if (widx < `AOCM_PARAM_BYTES) begin
               s_d.prdata[7:0] = s_q.param[widx[2:0]];
            end else if (paddr == `AOCM_OFS_DIAG_REC) begin
               s_d.prdata = s_q.diag_rec;
            end else if (paddr == `AOCM_OFS_STATUS) begin
               s_d.prdata = diag_now;
            end
         end
      end

      if (access && pwrite && mapped && s_q.loaded) begin
         if (widx < `AOCM_PARAM_BYTES) begin
            if (pstrb[0]) begin
               s_d.nv_save = 1'b1;
               if (widx == `AOCM_IDX_ALARM_CFG) begin
                  s_d.param[0] = 8'h00;
                  s_d.param[0][`AOCM_ALARM_EN_BIT] = pwdata[`AOCM_ALARM_EN_BIT];
               end else if (widx != `AOCM_IDX_SPARE) begin
                  s_d.param[widx[2:0]] = pwdata[7:0];
               end
            end
         end else if (out_hit) begin
            // The high byte is the later byte of the channel in the output area.
            if (pstrb[1]) begin
               s_d.word[out_ch][15:8] = pwdata[15:8];
            end
            if (pstrb[0]) begin
               s_d.word[out_ch][7:0] = pwdata[7:0];
            end
         end
      end

      // A new error is reported once; a burst of faults while one record is
      // waiting is dropped, neither folded into that record nor queued.
      case (s_q.diag_state)
         aocm_pkg::AOCM_DIAG_IDLE: begin
            if (err_any && !s_q.err_seen
                  && s_q.param[`AOCM_IDX_ALARM_CFG][`AOCM_ALARM_EN_BIT]) begin
               s_d.diag_state = aocm_pkg::AOCM_DIAG_SEND;
               s_d.diag_rec = diag_now;
            end
         end
         aocm_pkg::AOCM_DIAG_SEND: begin
            if (diag_ready) begin
               s_d.diag_state = aocm_pkg::AOCM_DIAG_IDLE;
            end
         end
         default: begin
            s_d.diag_state = aocm_pkg::AOCM_DIAG_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign pready = s_q.pready;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr;
   assign nv_image_out = s_q.param;
   assign nv_save = s_q.nv_save;
   assign diag_valid = (s_q.diag_state == aocm_pkg::AOCM_DIAG_SEND);
   assign diag_record = s_q.diag_rec;

endmodule

// ===== verif/aocm_properties.sv
// Port-level checks of the analog output code mapper.
`timescale 1ns/100ps
module aocm_properties (
   input wire logic clock,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic nv_save,
   input wire logic diag_valid,
   input wire logic [31:0] diag_record,
   input wire logic diag_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_slverr_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_save_pulse: assert property (nv_save |=> !nv_save)
      else $error("store pulse too long");
   // The store pulse follows the accepted write by exactly one cycle.
   a_save_cause: assert property (nv_save |-> $past(psel && penable && pready && pwrite))
      else $error("store pulse without a write");
   a_diag_hold: assert property (diag_valid && !diag_ready |=>
      diag_valid && $stable(diag_record))
      else $error("record dropped before acceptance");
   a_diag_release: assert property (diag_valid && diag_ready |=> !diag_valid)
      else $error("record kept after acceptance");
   a_diag_spare_zero: assert property (diag_valid |->
      diag_record[31:16] == 16'h0000 && diag_record[7:4] == 4'h0)
      else $error("unused record bits not zero");
   a_diag_class: assert property (diag_valid |->
      diag_record[11:8] == 4'b0101 && !diag_record[1])
      else $error("record class or zero bit wrong");
endmodule
bind aocm_top aocm_properties u_props (
   .clock(clock),
   .resetn(resetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pready(pready),
   .pslverr(pslverr),
   .nv_save(nv_save),
   .diag_valid(diag_valid),
   .diag_record(diag_record),
   .diag_ready(diag_ready)
);

// ===== verif/aocm_diag_sink.sv
// Master-side receiver of diagnostic records, prompt or slow.
`timescale 1ns/100ps
module aocm_diag_sink (
   input wire logic clock,
   input wire logic resetn,
   input wire logic diag_valid,
   input wire logic [31:0] diag_record,
   input wire logic slow,
   output logic diag_ready,
   output logic [31:0] last_rec,
   output int got
);
   int cnt;
   // Ready is raised only while a record is offered, never left high idle.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         diag_ready <= 1'b0;
         cnt <= 0;
         last_rec <= 32'h0000_0000;
         got <= 0;
      end else if (diag_valid && !diag_ready) begin
         if (cnt >= (slow ? 3 : 0)) begin
            diag_ready <= 1'b1;
         end else begin
            cnt <= cnt + 1;
         end
      end else begin
         diag_ready <= 1'b0;
         cnt <= 0;
         if (diag_valid && diag_ready) begin
            last_rec <= diag_record;
            got <= got + 1;
         end
      end
   end
endmodule

// ===== verif/aocm_tb_top.sv
// Self-checking bench of the analog output code mapper.
`timescale 1ns/100ps
module aocm_tb_top;
   typedef struct packed {
      logic [7:0] fn;
      logic [15:0] w;
      logic [15:0] l;
      logic [3:0] r;
   } aocm_row_type;
   aocm_row_type rows [17] = '{
      '{8'h01, 16'h4000, 16'h6C00, 4'h1},
      '{8'h01, 16'hC000, 16'h9400, 4'h1},
      '{8'h05, 16'h4000, 16'h6C00, 4'h2},
      '{8'h02, 16'h2000, 16'h3600, 4'h3},
      '{8'h01, 16'h4003, 16'h6C00, 4'h1},
      '{8'h04, 16'h2000, 16'h3600, 4'h4},
      '{8'h03, 16'hC000, 16'h9400, 4'h5},
      '{8'h06, 16'h4000, 16'h6C00, 4'h6},
      '{8'h09, 16'h9400, 16'h9400, 4'h1},
      '{8'h0A, 16'h3600, 16'h3600, 4'h3},
      '{8'h0F, 16'h9400, 16'h9400, 4'h7},
      '{8'h10, 16'h6C00, 16'h6C00, 4'h8},
      '{8'h0C, 16'h3600, 16'h3600, 4'h4},
      '{8'h0B, 16'h9400, 16'h9400, 4'h5},
      '{8'h0D, 16'h6C00, 16'h6C00, 4'h2},
      '{8'h00, 16'h4000, 16'h0000, 4'h0},
      '{8'h0E, 16'h6C00, 16'h6C00, 4'h6}};
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic module_fault = 1'b0;
   logic [3:0] channel_fault = 4'h0;
   logic slow = 1'b0;
   logic pready, pslverr, nv_save, diag_valid, diag_ready, err;
   logic [31:0] prdata, diag_record, last_rec, rd;
   logic [47:0] nv_image_out;
   logic [47:0] nv_store = 48'h0C0B_0A09_0040;
   logic [63:0] channel_level;
   logic [15:0] channel_range;
   int got, n0, c;
   int fails = 0;
   int cmp_count = 0;
   always #2 clock = ~clock;
   // Parameter storage survives a reset, so a reload shows what was last saved.
   always @(posedge clock) begin
      if (nv_save) begin
         nv_store <= nv_image_out;
      end
   end
   aocm_top dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .nv_image_in(nv_store), .nv_image_out(nv_image_out),
      .nv_save(nv_save), .module_fault(module_fault), .channel_fault(channel_fault),
      .channel_level(channel_level), .channel_range(channel_range), .diag_valid(diag_valid),
      .diag_record(diag_record), .diag_ready(diag_ready));
   aocm_diag_sink sink (.clock(clock), .resetn(resetn), .diag_valid(diag_valid),
      .diag_record(diag_record), .slow(slow), .diag_ready(diag_ready), .last_rec(last_rec),
      .got(got));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task close_out;
      $display("compared %0d, mismatched %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("alarm cfg", 32'h0000_0040, rd);
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk("ch3 fn", 32'h0000_000C, rd);
      chk("ch3 range", 32'h0000_0004, 32'(channel_range[15:12]));
      $display("reset test done");
      // The channel rotates through all four, but each row checks only the channel that it set.
      for (int i = 0; i < 17; i++) begin
         c = i % 4;
         apb(1'b1, 8'h08 + 8'(4 * c), {24'h00_0000, rows[i].fn});
         apb(1'b1, 8'h20 + 8'(4 * c), {16'h0000, rows[i].w});
         repeat (3) @(posedge clock);
         chk("level", {16'h0000, rows[i].l}, {16'h0000, channel_level[16 * c +: 16]});
         chk("range", {28'h000_0000, rows[i].r}, 32'(channel_range[4 * c +: 4]));
      end
      $display("mapping table done");
      apb(1'b1, 8'h08, 32'h0000_0009);
      repeat (2) @(posedge clock);
      chk("stored fn", 32'h0000_0009, 32'(nv_image_out[23:16]));
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("reserved bits", 32'h0000_0040, rd);
      apb(1'b1, 8'h04, 32'hFFFF_FFFF);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("spare byte", 32'h0000_0000, rd);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, 32'(err));
      $display("register test done");
      n0 = got;
      channel_fault <= 4'h1;
      while (got == n0) @(posedge clock);
      chk("channel record", 32'h0000_150C, last_rec);
      channel_fault <= 4'h0;
      slow <= 1'b1;
      repeat (4) @(posedge clock);
      n0 = got;
      module_fault <= 1'b1;
      while (got == n0) @(posedge clock);
      chk("module record", 32'h0000_0501, last_rec);
      apb(1'b0, 8'h30, 32'h0000_0000);
      chk("record readback", 32'h0000_0501, rd);
      module_fault <= 1'b0;
      apb(1'b1, 8'h14, 32'h0000_0007);
      apb(1'b0, 8'h34, 32'h0000_0000);
      chk("bad fn status", 32'h0000_0501, rd);
      apb(1'b1, 8'h14, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_0000);
      repeat (10) @(posedge clock);
      n0 = got;
      channel_fault <= 4'h2;
      repeat (20) @(posedge clock);
      chk("alarm inhibited", 32'(n0), 32'(got));
      $display("diagnostic test done");
      resetn <= 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("kept ch0 fn", 32'h0000_0009, rd);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("kept alarm cfg", 32'h0000_0000, rd);
      chk("kept ch0 range", 32'h0000_0001, 32'(channel_range[3:0]));
      $display("power cycle test done");
      close_out;
   end
   initial begin
      #80000;
      fails++;
      close_out;
   end
endmodule
